// ---- hw/emb_pkg.sv ----
package emb_pkg;

	// Bus widths, buffer size and synchroniser depth
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned SYNC_STAGES = 3;

	// Machine cycle: six states of two oscillator clocks, two bus slots
	localparam logic [2:0] ST_SLOT0_END = 3'h2;
	localparam logic [2:0] ST_SLOT1 = 3'h3;
	localparam logic [2:0] ST_LAST = 3'h5;
	localparam logic [2:0] ALE_POS_END = 3'h2;

	// Reset qualification at the fifth state, second phase
	localparam logic [2:0] RST_SAMPLE_ST = 3'h4;
	localparam logic RST_SAMPLE_PH = 1'b1;
	localparam logic [1:0] RST_QUAL_SAMPLES = 2'h2;

	// On-chip program store limit and auxiliary control location
	localparam logic [15:0] IROM_LIMIT = 16'h4000;
	localparam logic [7:0] AUX_CTRL_ADDR = 8'h8E;
	localparam int unsigned AUX_ALE_OFF_BIT = 0;

	// Pin reset values
	localparam logic [7:0] PORT_IDLE = 8'hFF;

	// Bus operation of one slot
	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_IFETCH = 2'b01,
		OP_XFETCH = 2'b11,
		OP_DATA = 2'b10
	} emb_op_e;

	// External bus pins
	typedef struct packed {
		logic ale;
		logic program_store_strobe_b;
		logic rd_b;
		logic wr_b;
		logic [7:0] p0_out;
		logic p0_oe;
		logic [7:0] p2_out;
	} emb_bus_s;

	// Data memory request from the core
	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} emb_mreq_s;

endpackage : emb_pkg

// ---- hw/emb_fifo.sv ----
module emb_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Filling side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Draining side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int unsigned CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] next_mem [DEPTH];
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic [CNT_W-1:0] wr_idx;
	logic do_push;
	logic do_pop;

	// Head always sits in entry 0 so the output comes straight from a flop
	assign do_push = in_valid && in_ready;
	assign do_pop = out_valid && out_ready;
	assign wr_idx = do_pop ? count - CNT_W'(1) : count;
	assign out_data = mem[0];

	always_comb begin
		next_count = count;
		if (do_push && !do_pop) begin
			next_count = count + CNT_W'(1);
		end else if (do_pop && !do_push) begin
			next_count = count - CNT_W'(1);
		end
	end

	// Each entry shifts toward the head on a pop and takes new data at the tail
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		always_comb begin
			next_mem[i] = mem[i];
			if (do_pop) begin
				if (i < DEPTH - 1) begin
					next_mem[i] = mem[(i < DEPTH - 1) ? i + 1 : i];
				end
			end
			if (do_push && wr_idx == CNT_W'(i)) begin
				next_mem[i] = in_data;
			end
		end
		always_ff @(posedge core_clk) begin
			mem[i] <= next_mem[i];
		end
	end

	// Flags registered from the next count, so they are honest every cycle
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			count <= '0;
			out_valid <= 1'b0;
			in_ready <= 1'b0;
		end else begin
			count <= next_count;
			out_valid <= (next_count != '0);
			in_ready <= (next_count != FULL);
		end
	end

endmodule : emb_fifo

// ---- hw/emb_ctrl.sv ----
module emb_ctrl
	import emb_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Device pins
	input wire logic external_fetch_select_b,
	input wire logic reset_pin,
	input wire logic [7:0] p0_in,
	output emb_bus_s bus_pins,
	// Auxiliary control bit 0, held by the core
	input wire logic aux_ale_off,
	// Code fetch requests
	input wire logic fetch_req,
	input wire logic [15:0] fetch_addr,
	output logic fetch_taken,
	// On-chip program store
	output logic [15:0] irom_addr,
	input wire logic [7:0] irom_data,
	// Fetched code bytes
	output logic code_valid,
	output logic [7:0] code_data,
	input wire logic code_ready,
	// Data memory requests
	input wire logic data_req,
	input wire emb_mreq_s data_cmd,
	output logic data_taken,
	output logic data_done,
	output logic [7:0] data_rdata,
	// Qualified reset to the core
	output logic core_reset
);

	// Pin synchronisers and reset qualification state
	logic [SYNC_STAGES-1:0] sel_sync;
	logic [SYNC_STAGES-1:0] rst_sync;
	logic [7:0] p0_sync [SYNC_STAGES];
	logic sel_lvl;
	logic rst_lvl;
	logic [1:0] rst_cnt;
	logic next_sel_lvl;
	logic next_rst_lvl;
	logic [1:0] next_rst_cnt;
	logic next_core_reset;

	// Bus sequencer state
	logic phase;
	logic [2:0] state;
	emb_op_e op;
	logic [15:0] addr;
	logic we;
	logic [7:0] wdata;
	logic next_phase;
	logic [2:0] next_state;
	emb_op_e next_op;
	logic [15:0] next_addr;
	logic next_we;
	logic [7:0] next_wdata;
	logic next_fetch_taken;
	logic next_data_taken;
	logic next_data_done;
	logic [7:0] next_rdata;
	logic [15:0] next_irom_addr;
	emb_bus_s next_bus;
	logic push;
	logic [7:0] push_data;
	logic next_push;
	logic [7:0] next_push_data;
	logic fifo_in_ready;
	logic slot_end;
	logic ext_op;
	logic [2:0] pos;
	logic [4:0] credit;
	logic [4:0] next_credit;
	logic aux_quiet;
	logic next_aux_quiet;

	// Three-stage synchronisers; only the last two stages are compared
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			sel_sync <= '1;
			rst_sync <= '0;
			p0_sync <= '{default: PORT_IDLE};
		end else begin
			sel_sync <= {sel_sync[SYNC_STAGES-2:0], external_fetch_select_b};
			rst_sync <= {rst_sync[SYNC_STAGES-2:0], reset_pin};
			p0_sync <= '{p0_in, p0_sync[0], p0_sync[1]};
		end
	end

	// Levels change only when stages two and three agree, which also drops glitches
	always_comb begin
		next_sel_lvl = sel_lvl;
		next_rst_lvl = rst_lvl;
		if (sel_sync[1] == sel_sync[2]) begin
			next_sel_lvl = sel_sync[2];
		end
		if (rst_sync[1] == rst_sync[2]) begin
			next_rst_lvl = rst_sync[2];
		end
	end

	// One reset sample per machine cycle at the fixed sample phase
	always_comb begin
		next_rst_cnt = rst_cnt;
		next_core_reset = core_reset;
		if (state == RST_SAMPLE_ST && phase == RST_SAMPLE_PH) begin
			if (!rst_lvl) begin
				next_rst_cnt = '0;
			end else if (rst_cnt != RST_QUAL_SAMPLES) begin
				next_rst_cnt = rst_cnt + 2'h1;
			end
			// Two consecutive high samples are needed; one short pulse does nothing
			next_core_reset = rst_lvl && (rst_cnt + 2'h1 >= RST_QUAL_SAMPLES);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			sel_lvl <= 1'b1;
			rst_lvl <= 1'b0;
			rst_cnt <= '0;
			core_reset <= 1'b0;
		end else begin
			sel_lvl <= next_sel_lvl;
			rst_lvl <= next_rst_lvl;
			rst_cnt <= next_rst_cnt;
			core_reset <= next_core_reset;
		end
	end

	// Timing base: phase halves the oscillator, state steps once per two clocks
	assign slot_end = phase && (state == ST_SLOT0_END || state == ST_LAST);

	// Completion of the running slot, then choice of the next slot's operation
	always_comb begin
		next_phase = ~phase;
		next_state = state;
		if (phase) begin
			next_state = (state == ST_LAST) ? 3'h0 : state + 3'h1;
		end
		next_op = op;
		next_addr = addr;
		next_we = we;
		next_wdata = wdata;
		next_fetch_taken = 1'b0;
		next_data_taken = 1'b0;
		next_data_done = 1'b0;
		next_rdata = data_rdata;
		next_irom_addr = irom_addr;
		next_push = 1'b0;
		next_push_data = push_data;
		if (slot_end) begin
			case (op)
				OP_XFETCH: begin
					next_push = 1'b1;
					next_push_data = p0_sync[SYNC_STAGES-1];
				end
				OP_IFETCH: begin
					next_push = 1'b1;
					next_push_data = irom_data;
				end
				OP_DATA: begin
					if (state == ST_LAST) begin
						next_data_done = 1'b1;
						next_rdata = we ? wdata : p0_sync[SYNC_STAGES-1];
					end
				end
				default: begin
					next_push = 1'b0;
				end
			endcase
			if (op == OP_DATA && state == ST_SLOT0_END) begin
				next_op = OP_DATA;
			end else if (core_reset) begin
				// The core is held in reset: no new bus traffic starts
				next_op = OP_NONE;
			end else if (data_req && state == ST_LAST) begin
				// Data accesses take a whole machine cycle, so they start only at slot 0
				next_op = OP_DATA;
				next_addr = data_cmd.addr;
				next_we = data_cmd.we;
				next_wdata = data_cmd.wdata;
				next_data_taken = 1'b1;
			end else if (fetch_req && fifo_in_ready && credit != 5'(FIFO_DEPTH)) begin
				// A fetch starts only while the buffer has room for its byte
				next_fetch_taken = 1'b1;
				next_addr = fetch_addr;
				next_irom_addr = fetch_addr;
				if (sel_lvl && fetch_addr < IROM_LIMIT) begin
					next_op = OP_IFETCH;
				end else begin
					next_op = OP_XFETCH;
				end
			end else begin
				next_op = OP_NONE;
			end
		end
	end

	// Credit counts bytes owed to the core, the one still on the bus included,
	// because the buffer's ready flag cannot see a byte that has not arrived yet
	always_comb begin
		next_credit = credit;
		if (next_fetch_taken && !(code_valid && code_ready)) begin
			next_credit = credit + 5'h01;
		end else if (!next_fetch_taken && code_valid && code_ready) begin
			next_credit = credit - 5'h01;
		end
		// Quiet mode is taken only at slot boundaries, so no latch pulse is ever cut short
		next_aux_quiet = slot_end ? aux_ale_off : aux_quiet;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			credit <= '0;
			aux_quiet <= 1'b0;
		end else begin
			credit <= next_credit;
			aux_quiet <= next_aux_quiet;
		end
	end

	// Pin values for the coming clock, derived from the next timing position
	always_comb begin
		pos = (next_state >= ST_SLOT1) ? 3'((next_state - ST_SLOT1) * 3'h2 + {2'h0, next_phase})
			: 3'(next_state * 3'h2 + {2'h0, next_phase});
		ext_op = (next_op == OP_XFETCH) || (next_op == OP_DATA);
		next_bus = bus_pins;
		// Runs every three states unless the data cycle or quiet mode drops it
		next_bus.ale = (pos < ALE_POS_END)
			&& !(next_op == OP_DATA && next_state >= ST_SLOT1)
			&& (!next_aux_quiet || ext_op);
		next_bus.program_store_strobe_b = !(next_op == OP_XFETCH && pos >= ALE_POS_END);
		next_bus.rd_b = !(next_op == OP_DATA && !next_we && next_state != 3'h0);
		next_bus.wr_b = !(next_op == OP_DATA && next_we && next_state != 3'h0);
		next_bus.p0_oe = 1'b0;
		next_bus.p0_out = PORT_IDLE;
		if (ext_op && next_state != 3'h0 && !(next_op == OP_DATA && next_state >= 3'h1) && pos < ALE_POS_END) begin
			next_bus.p0_oe = 1'b0;
		end
		if (ext_op && pos < ALE_POS_END && !(next_op == OP_DATA && next_state >= ST_SLOT1)) begin
			// Low address byte stands on the port while the latch strobe is high
			next_bus.p0_oe = 1'b1;
			next_bus.p0_out = next_addr[7:0];
		end else if (next_op == OP_DATA && next_we && next_state != 3'h0) begin
			next_bus.p0_oe = 1'b1;
			next_bus.p0_out = next_wdata;
		end
		if (ext_op) begin
			next_bus.p2_out = next_addr[15:8];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			// Parked on the last clock of a slot, so the first pins after release open a whole slot
			phase <= 1'b1;
			state <= ST_LAST;
			op <= OP_NONE;
			addr <= '0;
			we <= 1'b0;
			wdata <= '0;
			fetch_taken <= 1'b0;
			data_taken <= 1'b0;
			data_done <= 1'b0;
			data_rdata <= '0;
			irom_addr <= '0;
			push <= 1'b0;
			push_data <= '0;
			bus_pins <= '{ale: 1'b0, program_store_strobe_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1,
				p0_out: PORT_IDLE, p0_oe: 1'b0, p2_out: PORT_IDLE};
		end else begin
			phase <= next_phase;
			state <= next_state;
			op <= next_op;
			addr <= next_addr;
			we <= next_we;
			wdata <= next_wdata;
			fetch_taken <= next_fetch_taken;
			data_taken <= next_data_taken;
			data_done <= next_data_done;
			data_rdata <= next_rdata;
			irom_addr <= next_irom_addr;
			push <= next_push;
			push_data <= next_push_data;
			bus_pins <= next_bus;
		end
	end

	// Fetched bytes queue toward the core; a full queue holds off new fetches
	emb_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_code_fifo (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.in_valid(push),
		.in_data(push_data),
		.in_ready(fifo_in_ready),
		.out_valid(code_valid),
		.out_data(code_data),
		.out_ready(code_ready)
	);

endmodule : emb_ctrl

// ---- verif/emb_ctrl_properties.sv ----
module emb_ctrl_properties
	import emb_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Pins
	input wire logic external_fetch_select_b,
	input wire logic reset_pin,
	input wire logic aux_ale_off,
	input wire emb_bus_s bus_pins,
	// Core side
	input wire logic [15:0] fetch_addr,
	input wire logic fetch_taken,
	input wire logic data_taken,
	input wire logic data_done,
	input wire emb_mreq_s data_cmd,
	input wire logic core_reset
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	wire ale = bus_pins.ale;
	wire ps_b = bus_pins.program_store_strobe_b;
	wire oe = bus_pins.p0_oe;
	wire sel = external_fetch_select_b;
	logic [5:0] hi_cnt;
	logic [5:0] next_hi_cnt;
	// Run length of the reset pin, saturating so a long hold cannot wrap
	always_comb begin
		next_hi_cnt = 6'h00;
		if (reset_pin) begin
			next_hi_cnt = (hi_cnt == 6'h3F) ? hi_cnt : hi_cnt + 6'h01;
		end
	end
	always_ff @(posedge core_clk) begin
		hi_cnt <= next_hi_cnt;
	end
	// Select is compared four cycles back because the pin passes a synchroniser
	AST_INT_FETCH: assert property (fetch_taken && sel && $past(sel, 4) && fetch_addr < IROM_LIMIT
		|-> !oe ##2 ps_b [*4]) else $error("internal fetch showed on the bus");
	AST_EXT_FETCH: assert property (fetch_taken && sel == $past(sel, 4)
		&& (!sel || fetch_addr >= IROM_LIMIT) |-> oe ##2 !ps_b [*4]) else $error("external fetch strobe wrong");
	AST_ADDR_OUT: assert property (fetch_taken && oe |-> bus_pins.p0_out == fetch_addr[7:0]
		&& bus_pins.p2_out == fetch_addr[15:8]) else $error("fetch address not on the ports");
	AST_ALE_WIDTH: assert property ($rose(ale) |-> ##1 ale ##1 !ale)
		else $error("latch strobe width wrong");
	AST_ALE_PERIOD: assert property ($rose(ale) && !data_taken |-> ##6 (ale || aux_ale_off
		|| $past(aux_ale_off, 2) || core_reset)) else $error("latch strobe period broken");
	AST_DATA_SKIP: assert property (data_taken |-> ale ##6 !ale [*2])
		else $error("data cycle kept its second latch pulse");
	AST_DATA_DONE: assert property (data_taken |-> ##12 data_done)
		else $error("data access not done in one machine cycle");
	AST_WR_DRIVE: assert property (data_taken && data_cmd.we |-> ##2 oe
		&& bus_pins.p0_out == $past(data_cmd.wdata, 2) ##0 !bus_pins.wr_b [*8]) else $error("write strobe wrong");
	AST_RST_QUAL: assert property ($rose(core_reset) |-> hi_cnt > 6'h0C)
		else $error("core reset on a short pin pulse");
endmodule : emb_ctrl_properties

bind emb_ctrl emb_ctrl_properties emb_ctrl_properties_inst (
	.core_clk(core_clk),
	.rst_b(rst_b),
	.external_fetch_select_b(external_fetch_select_b),
	.reset_pin(reset_pin),
	.aux_ale_off(aux_ale_off),
	.bus_pins(bus_pins),
	.fetch_addr(fetch_addr),
	.fetch_taken(fetch_taken),
	.data_taken(data_taken),
	.data_done(data_done),
	.data_cmd(data_cmd),
	.core_reset(core_reset)
);

// ---- verif/emb_mem_model.sv ----
module emb_mem_model
	import emb_pkg::*;
(
	// Clock
	input wire logic core_clk,
	// Bus from the device
	input wire emb_bus_s bus_pins,
	// Low port level seen by the device
	output logic [7:0] p0_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] lat;
	logic [7:0] last_drv = 8'h00;
	logic [7:0] ram [0:65535];
	logic [15:0] a;
	assign a = {bus_pins.p2_out, lat};
	// Address latch follows the port while the strobe is high; RAM takes writes
	always @(posedge core_clk) begin
		if (bus_pins.p0_oe) begin
			last_drv <= bus_pins.p0_out;
		end
		if (bus_pins.ale) begin
			lat <= bus_pins.p0_out;
		end
		if (!bus_pins.wr_b) begin
			ram[a] <= bus_pins.p0_out;
		end
	end
	// Open drain without a pull-up: a released port shows the inverse of its last driven byte
	always_comb begin
		if (bus_pins.p0_oe) begin
			p0_in = bus_pins.p0_out;
		end else if (!bus_pins.program_store_strobe_b) begin
			p0_in = a[7:0] ^ a[15:8] ^ 8'h5A;
		end else if (!bus_pins.rd_b) begin
			p0_in = ram[a];
		end else begin
			p0_in = ~last_drv;
		end
	end
endmodule : emb_mem_model

// ---- verif/tb_external_memory_bus_control.sv ----
module tb_external_memory_bus_control
	import emb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic external_fetch_select_b = 1'b1;
	logic reset_pin = 1'b0;
	logic aux_ale_off = 1'b0;
	logic fetch_req = 1'b0;
	logic [15:0] fetch_addr = 16'h0000;
	logic code_ready = 1'b1;
	logic data_req = 1'b0;
	emb_mreq_s data_cmd = '0;
	logic [7:0] p0_in, irom_data, code_data, data_rdata;
	logic [15:0] irom_addr;
	logic fetch_taken, code_valid, data_taken, data_done, core_reset, ale_at_take;
	emb_bus_s bus_pins;
	int fails = 0;
	int n_checks = 0;
	int i, cnt;
	always #5 core_clk = ~core_clk;
	function automatic logic [7:0] ext_b(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction : ext_b
	function automatic logic [7:0] int_b(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hA5;
	endfunction : int_b
	// On-chip store answers from the bench with a pattern unlike the external one
	assign irom_data = int_b(irom_addr);
	emb_ctrl emb_ctrl_inst (.core_clk(core_clk), .rst_b(rst_b), .external_fetch_select_b(external_fetch_select_b),
		.reset_pin(reset_pin), .p0_in(p0_in), .bus_pins(bus_pins), .aux_ale_off(aux_ale_off),
		.fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_taken(fetch_taken), .irom_addr(irom_addr),
		.irom_data(irom_data), .code_valid(code_valid), .code_data(code_data), .code_ready(code_ready),
		.data_req(data_req), .data_cmd(data_cmd), .data_taken(data_taken), .data_done(data_done),
		.data_rdata(data_rdata), .core_reset(core_reset));
	emb_mem_model emb_mem_model_inst (.core_clk(core_clk), .bus_pins(bus_pins), .p0_in(p0_in));
	task automatic end_of_test;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask : tick
	function automatic logic sig(input int k);
		case (k)
			0: return fetch_taken;
			1: return data_taken;
			2: return data_done;
			default: return code_valid;
		endcase
	endfunction : sig
	// Bounded wait for a handshake; running out ends the run as a failure
	task automatic await(input int k);
		i = 0;
		while (sig(k) !== 1'b1 && i < 80) begin
			tick(1);
			i++;
		end
		if (i >= 80) begin
			fails++;
			end_of_test;
		end
	endtask : await
	task automatic issue(input logic [15:0] a);
		fetch_req = 1'b1;
		fetch_addr = a;
		await(0);
		ale_at_take = bus_pins.ale;
		fetch_req = 1'b0;
		tick(1);
	endtask : issue
	task automatic pop(input logic [7:0] e);
		await(3);
		chk(code_data, e);
		tick(1);
	endtask : pop
	task automatic t_fetch(input logic sel, input logic [15:0] a, input logic [7:0] e);
		external_fetch_select_b = sel;
		tick(8);
		issue(a);
		pop(e);
	endtask : t_fetch
	task automatic dop(input logic we, input logic [15:0] a, input logic [7:0] d, input logic [7:0] e);
		data_cmd = '{we: we, addr: a, wdata: d};
		data_req = 1'b1;
		await(1);
		data_req = 1'b0;
		await(2);
		chk(data_rdata, e);
	endtask : dop
	task automatic t_ale(input logic off, input logic [15:0] e);
		aux_ale_off = off;
		tick(8);
		cnt = 0;
		repeat (60) begin
			tick(1);
			cnt += bus_pins.ale;
		end
		chk(cnt[15:0], e);
	endtask : t_ale
	// Fill the buffer with the consumer stalled, see one refusal, then drain in order
	task automatic t_fifo;
		code_ready = 1'b0;
		for (int k = 0; k < 16; k++) begin
			issue(16'h8000 + k[15:0]);
		end
		fetch_req = 1'b1;
		fetch_addr = 16'h8010;
		cnt = 0;
		repeat (30) begin
			tick(1);
			cnt += fetch_taken;
		end
		chk(cnt[15:0], 16'h0000);
		code_ready = 1'b1;
		pop(ext_b(16'h8000));
		code_ready = 1'b0;
		await(0);
		fetch_req = 1'b0;
		code_ready = 1'b1;
		for (int k = 1; k < 17; k++) begin
			pop(ext_b(16'h8000 + k[15:0]));
		end
	endtask : t_fifo
	task automatic t_rst;
		reset_pin = 1'b1;
		tick(6);
		reset_pin = 1'b0;
		tick(20);
		chk(core_reset, 1'b0);
		reset_pin = 1'b1;
		tick(40);
		chk(core_reset, 1'b1);
		reset_pin = 1'b0;
		tick(20);
		chk(core_reset, 1'b0);
	endtask : t_rst
	initial begin
		tick(12);
		rst_b = 1'b1;
		tick(2);
		t_ale(1'b0, 16'h0014);
		t_ale(1'b1, 16'h0000);
		t_fetch(1'b0, 16'h8123, ext_b(16'h8123));
		chk(ale_at_take, 1'b1);
		aux_ale_off = 1'b0;
		t_fetch(1'b1, 16'h3FFF, int_b(16'h3FFF));
		t_fetch(1'b1, 16'h4000, ext_b(16'h4000));
		t_fetch(1'b0, 16'h0010, ext_b(16'h0010));
		t_fetch(1'b0, 16'hFFFF, ext_b(16'hFFFF));
		dop(1'b1, 16'hBE34, 8'h3C, 8'h3C);
		dop(1'b1, 16'h0034, 8'hC3, 8'hC3);
		dop(1'b0, 16'hBE34, 8'h00, 8'h3C);
		dop(1'b0, 16'h0034, 8'h00, 8'hC3);
		t_fetch(1'b0, 16'hBE34, ext_b(16'hBE34));
		t_fifo;
		t_rst;
		end_of_test;
	end
endmodule : tb_external_memory_bus_control
